// ---- hdl/dsf_params.svh ----
// Purpose: constants for the debug status flag block
// Assumes: one 25 MHz clock, classic wishbone register access
// Notes: byte offsets are word aligned
`ifndef DSF_PARAMS_SVH
`define DSF_PARAMS_SVH
`define DSF_OFS_DBG_CS 4'h0
`define DSF_OFS_IRQ_STAT 4'h4
`define DSF_OFS_IRQ_MASK 4'h8
`define DSF_OFS_RET_PC 4'hc
`define DSF_BIT_SSC 0
`define DSF_BIT_SWB 1
`define DSF_BIT_LDB 2
`define DSF_BIT_STB 3
`define DSF_BIT_IAB 4
`define DSF_BIT_DIN 5
`define DSF_BIT_TRS 7
`define DSF_BIT_SSE 8
`define DSF_BIT_BSF 10
`define DSF_BIT_TLF 11
`define DSF_BIT_OES 12
`define DSF_BIT_ACT 30
`define DSF_CS_RESET 32'h0000_0000
`define DSF_PC_RESET 32'h0000_0000
`define DSF_IRQ_W 3
`define DSF_IRQ_ENTRY 0
`define DSF_IRQ_TLB 1
`define DSF_IRQ_BUS 2
`define DSF_BAD_DATA 32'h0000_0000
`endif

// ---- hdl/dsf_pkg.sv ----
// Purpose: types for the debug status flag block
// Assumes: dsf_params.svh holds the numbers
// Notes: nothing is imported
package dsf_pkg;
    // debug exception causes reported by the pipeline
    typedef struct packed {
        logic take;
        logic single_step;
        logic sw_break;
        logic load_break;
        logic store_break;
        logic instr_break;
        logic dbg_int;
        logic other_exc;
        logic [31:0] pc;
    } dsf_entry_t;
    // faults seen while the handler runs
    typedef struct packed {
        logic tlb_fault;
        logic bus_fault;
        logic prior_ldst;
        logic ldst;
    } dsf_fault_t;
    typedef enum logic [1:0] {
        DSF_BUS_IDLE,
        DSF_BUS_ACK
    } dsf_bus_state_t;
endpackage

// ---- hdl/dsf_wb_slave.sv ----
// Purpose: classic wishbone slave front end for the debug status block
// Assumes: single cycle reads and writes, one word per register
// Notes: ack is registered, one wait state, dropped after one cycle
`timescale 1ns/100ps
`include "dsf_params.svh"
module dsf_wb_slave (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [3:0] wb_sel_i,
    output logic wb_ack_o,
    output logic [31:0] wb_dat_o,
    output logic wr_stb,
    output logic [3:0] wr_adr,
    output logic [31:0] wr_dat,
    output logic [3:0] wr_sel,
    input wire logic [31:0] rd_dat_a,
    input wire logic [31:0] rd_dat_b,
    input wire logic [31:0] rd_dat_c,
    input wire logic [31:0] rd_dat_d
);
    dsf_pkg::dsf_bus_state_t state_q;
    logic [31:0] rd_mux;

    always_comb begin
        case (wb_adr_i)
            `DSF_OFS_DBG_CS: rd_mux = rd_dat_a;
            `DSF_OFS_IRQ_STAT: rd_mux = rd_dat_b;
            `DSF_OFS_IRQ_MASK: rd_mux = rd_dat_c;
            `DSF_OFS_RET_PC: rd_mux = rd_dat_d;
            default: rd_mux = `DSF_BAD_DATA;
        endcase
    end

    // one access per request; ack never held two cycles
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            state_q <= dsf_pkg::DSF_BUS_IDLE;
            wb_ack_o <= 1'b0;
            wb_dat_o <= `DSF_BAD_DATA;
            wr_stb <= 1'b0;
            wr_adr <= 4'h0;
            wr_dat <= 32'h0000_0000;
            wr_sel <= 4'h0;
        end else begin
            wr_stb <= 1'b0;
            wb_ack_o <= 1'b0;
            case (state_q)
                dsf_pkg::DSF_BUS_IDLE: begin
                    if (wb_cyc_i && wb_stb_i) begin
                        state_q <= dsf_pkg::DSF_BUS_ACK;
                        wb_ack_o <= 1'b1;
                        wb_dat_o <= rd_mux;
                        wr_stb <= wb_we_i;
                        wr_adr <= wb_adr_i;
                        wr_dat <= wb_dat_i;
                        wr_sel <= wb_sel_i;
                    end
                end
                dsf_pkg::DSF_BUS_ACK: begin
                    state_q <= dsf_pkg::DSF_BUS_IDLE;
                end
                default: state_q <= dsf_pkg::DSF_BUS_IDLE;
            endcase
        end
    end
endmodule

// ---- hdl/dsf_debug_status.sv ----
// Purpose: debug control and status flags, low thirteen bits plus active bit
// Assumes: pipeline pulses entry, return and fault events on ref_clk
// Notes: register writes land the cycle after ack is given
//
// How it works
// - other exception with debug entry sets status
// - return pc never gets ordinary vector
// - tlb fault on prior ldst in handler sets flag
// - tlb flag: write zero clears, set wins
// - bus fault on ldst in handler sets flag
// - bus flag: write zero clears, set wins
// - single step enable, suppressed while handler active
// - test port reset driven while bit set
// - debug interrupt cause bit set on entry
// - instruction break cause bit set on entry
// - store data break cause bit set
// - load data break cause bit set
// - breakpoint instruction sets its cause bit
// - single step cause bit set on entry while single step enable set
// - active set on entry, cleared on return
//
// Design decisions made here: the register addresses and the Wishbone slave port.
`timescale 1ns/100ps
`include "dsf_params.svh"
module dsf_debug_status (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [3:0] wb_sel_i,
    output logic wb_ack_o,
    output logic [31:0] wb_dat_o,
    input wire dsf_pkg::dsf_entry_t entry_i,
    input wire logic return_i,
    input wire dsf_pkg::dsf_fault_t fault_i,
    output logic handler_active_q,
    output logic step_allowed_q,
    output logic test_port_reset_q,
    output logic [31:0] debug_return_pc_q,
    output logic irq_q
);
    logic wr_stb;
    logic [3:0] wr_adr;
    logic [31:0] wr_dat;
    logic [3:0] wr_sel;
    logic [31:0] cs_rd;
    logic [31:0] irq_stat_rd;
    logic [31:0] irq_mask_rd;
    logic cs_wr_lo;
    logic cs_wr_hi;
    logic tlb_set;
    logic bus_set;
    logic entry_ok;
    logic concurrent_other_exc_status_q;
    logic handler_tlb_fault_flag_q;
    logic handler_bus_fault_flag_q;
    logic single_step_enable_q;
    logic dbg_interrupt_cause_q;
    logic instr_addr_break_cause_q;
    logic store_data_break_cause_q;
    logic load_data_break_cause_q;
    logic sw_breakpoint_cause_q;
    logic single_step_cause_q;
    logic [`DSF_IRQ_W-1:0] irq_stat_q;
    logic [`DSF_IRQ_W-1:0] irq_stat_d;
    logic [`DSF_IRQ_W-1:0] irq_mask_q;
    logic [`DSF_IRQ_W-1:0] irq_mask_d;
    logic [`DSF_IRQ_W-1:0] irq_ev;

    // byte lane test shared by the cs, irq status and irq mask write decodes
    function automatic logic lane_hit(input logic [3:0] adr, input logic [3:0] sel,
                                      input logic [3:0] ofs, input int lane);
        lane_hit = (adr == ofs) && sel[lane];
    endfunction

    dsf_wb_slave u_bus (
        .ref_clk(ref_clk),
        .reset(reset),
        .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i),
        .wb_adr_i(wb_adr_i),
        .wb_dat_i(wb_dat_i),
        .wb_sel_i(wb_sel_i),
        .wb_ack_o(wb_ack_o),
        .wb_dat_o(wb_dat_o),
        .wr_stb(wr_stb),
        .wr_adr(wr_adr),
        .wr_dat(wr_dat),
        .wr_sel(wr_sel),
        .rd_dat_a(cs_rd),
        .rd_dat_b(irq_stat_rd),
        .rd_dat_c(irq_mask_rd),
        .rd_dat_d(debug_return_pc_q)
    );

    assign cs_wr_lo = wr_stb && lane_hit(wr_adr, wr_sel, `DSF_OFS_DBG_CS, 0);
    assign cs_wr_hi = wr_stb && lane_hit(wr_adr, wr_sel, `DSF_OFS_DBG_CS, 1);
    // a debug exception is masked while the handler runs
    assign entry_ok = entry_i.take && !handler_active_q;
    assign tlb_set = handler_active_q && fault_i.tlb_fault && fault_i.prior_ldst;
    assign bus_set = handler_active_q && fault_i.bus_fault && fault_i.ldst;

    always_comb begin
        cs_rd = `DSF_CS_RESET;
        cs_rd[`DSF_BIT_ACT] = handler_active_q;
        cs_rd[`DSF_BIT_OES] = concurrent_other_exc_status_q;
        cs_rd[`DSF_BIT_TLF] = handler_tlb_fault_flag_q;
        cs_rd[`DSF_BIT_BSF] = handler_bus_fault_flag_q;
        cs_rd[`DSF_BIT_SSE] = single_step_enable_q;
        cs_rd[`DSF_BIT_TRS] = test_port_reset_q;
        cs_rd[`DSF_BIT_DIN] = dbg_interrupt_cause_q;
        cs_rd[`DSF_BIT_IAB] = instr_addr_break_cause_q;
        cs_rd[`DSF_BIT_STB] = store_data_break_cause_q;
        cs_rd[`DSF_BIT_LDB] = load_data_break_cause_q;
        cs_rd[`DSF_BIT_SWB] = sw_breakpoint_cause_q;
        cs_rd[`DSF_BIT_SSC] = single_step_cause_q;
        irq_stat_rd = 32'h0000_0000;
        irq_stat_rd[`DSF_IRQ_W-1:0] = irq_stat_q;
        irq_mask_rd = 32'h0000_0000;
        irq_mask_rd[`DSF_IRQ_W-1:0] = irq_mask_q;
    end

    // handler active state
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            handler_active_q <= 1'b0;
        end else if (entry_ok) begin
            handler_active_q <= 1'b1;
        end else if (return_i) begin
            handler_active_q <= 1'b0;
        end
    end

    // cause bits are replaced as a set on each entry, software cannot write them
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            concurrent_other_exc_status_q <= 1'b0;
            dbg_interrupt_cause_q <= 1'b0;
            instr_addr_break_cause_q <= 1'b0;
            store_data_break_cause_q <= 1'b0;
            load_data_break_cause_q <= 1'b0;
            sw_breakpoint_cause_q <= 1'b0;
            single_step_cause_q <= 1'b0;
        end else if (entry_ok) begin
            concurrent_other_exc_status_q <= entry_i.other_exc;
            dbg_interrupt_cause_q <= entry_i.dbg_int;
            instr_addr_break_cause_q <= entry_i.instr_break;
            store_data_break_cause_q <= entry_i.store_break;
            load_data_break_cause_q <= entry_i.load_break;
            sw_breakpoint_cause_q <= entry_i.sw_break;
            single_step_cause_q <= entry_i.single_step && single_step_enable_q;
        end
    end

    // return pc takes the faulting pc, not a vector; software may overwrite
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            debug_return_pc_q <= `DSF_PC_RESET;
        end else if (entry_ok) begin
            debug_return_pc_q <= entry_i.pc;
        end else if (wr_stb && wr_adr == `DSF_OFS_RET_PC) begin
            for (int i = 0; i < 4; i++) begin
                if (wr_sel[i]) begin
                    debug_return_pc_q[i*8 +: 8] <= wr_dat[i*8 +: 8];
                end
            end
        end
    end

    // fault flags: hardware set beats a software clear
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            handler_tlb_fault_flag_q <= 1'b0;
            handler_bus_fault_flag_q <= 1'b0;
        end else begin
            if (tlb_set) begin
                handler_tlb_fault_flag_q <= 1'b1;
            end else if (cs_wr_hi && !wr_dat[`DSF_BIT_TLF]) begin
                handler_tlb_fault_flag_q <= 1'b0;
            end
            if (bus_set) begin
                handler_bus_fault_flag_q <= 1'b1;
            end else if (cs_wr_hi && !wr_dat[`DSF_BIT_BSF]) begin
                handler_bus_fault_flag_q <= 1'b0;
            end
        end
    end

    // software controls
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            single_step_enable_q <= 1'b0;
            test_port_reset_q <= 1'b0;
        end else begin
            if (cs_wr_hi) begin
                single_step_enable_q <= wr_dat[`DSF_BIT_SSE];
            end
            if (cs_wr_lo) begin
                test_port_reset_q <= wr_dat[`DSF_BIT_TRS];
            end
        end
    end

    // registered so the output comes from a flop; lags by one cycle
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            step_allowed_q <= 1'b0;
        end else begin
            step_allowed_q <= single_step_enable_q && !handler_active_q;
        end
    end

    assign irq_ev[`DSF_IRQ_ENTRY] = entry_ok;
    assign irq_ev[`DSF_IRQ_TLB] = tlb_set;
    assign irq_ev[`DSF_IRQ_BUS] = bus_set;

    // sticky events, write one to clear, a new event wins
    always_comb begin
        irq_stat_d = irq_stat_q;
        if (wr_stb && lane_hit(wr_adr, wr_sel, `DSF_OFS_IRQ_STAT, 0)) begin
            irq_stat_d = irq_stat_q & ~wr_dat[`DSF_IRQ_W-1:0];
        end
        irq_stat_d = irq_stat_d | irq_ev;
        // irq follows a mask write in the same edge, no stale cycle
        irq_mask_d = irq_mask_q;
        if (wr_stb && lane_hit(wr_adr, wr_sel, `DSF_OFS_IRQ_MASK, 0)) begin
            irq_mask_d = wr_dat[`DSF_IRQ_W-1:0];
        end
    end

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            irq_stat_q <= '0;
            irq_mask_q <= '0;
            irq_q <= 1'b0;
        end else begin
            irq_stat_q <= irq_stat_d;
            irq_mask_q <= irq_mask_d;
            irq_q <= |(irq_stat_d & irq_mask_d);
        end
    end
endmodule

// ---- bench/dsf_debug_status_asserts.sv ----
// Purpose: port checks for the debug status block
// Assumes: one clock domain, async active high reset
// Notes: bound to the top module
`timescale 1ns/100ps
module dsf_chk (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic wb_ack_o,
    input wire dsf_pkg::dsf_entry_t entry_i,
    input wire logic return_i,
    input wire logic handler_active_q,
    input wire logic step_allowed_q,
    input wire logic test_port_reset_q,
    input wire logic [31:0] debug_return_pc_q,
    input wire logic irq_q
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (reset);
    ack_one_cycle_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held too long");
    ack_latency_a: assert property (wb_cyc_i && $rose(wb_stb_i) |=> wb_ack_o)
        else $error("ack late");
    ack_cause_a: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
        else $error("ack without request");
    entry_active_a: assert property (entry_i.take && !(handler_active_q && return_i) |=>
        handler_active_q) else $error("active not set");
    return_clear_a: assert property (return_i && !entry_i.take |=> !handler_active_q)
        else $error("active not cleared");
    active_hold_a: assert property (!entry_i.take && !return_i |=> $stable(handler_active_q))
        else $error("active moved");
    step_blocked_a: assert property (handler_active_q |=> !step_allowed_q)
        else $error("step allowed in handler");
    entry_pc_a: assert property (entry_i.take && !handler_active_q |=>
        debug_return_pc_q == $past(entry_i.pc)) else $error("return pc wrong");
    port_rst_wr_a: assert property ($changed(test_port_reset_q) |->
        $past(wb_ack_o && wb_we_i)) else $error("port reset moved alone");
    irq_drop_wr_a: assert property ($fell(irq_q) |-> $past(wb_ack_o && wb_we_i))
        else $error("irq fell alone");
endmodule
bind dsf_debug_status dsf_chk u_chk (.ref_clk, .reset, .wb_cyc_i, .wb_stb_i, .wb_we_i,
    .wb_ack_o, .entry_i, .return_i, .handler_active_q, .step_allowed_q,
    .test_port_reset_q, .debug_return_pc_q, .irq_q);

// ---- bench/dsf_pipe.sv ----
// Purpose: exception pipeline model for the debug status block
// Assumes: events are single cycle pulses
// Notes: struct stays zero between events, no stale causes
`timescale 1ns/100ps
module dsf_pipe (
    input wire logic ref_clk,
    output dsf_pkg::dsf_entry_t entry,
    output logic ret,
    output dsf_pkg::dsf_fault_t fault
);
    initial begin
        entry = '0;
        ret = 1'b0;
        fault = '0;
    end
    // c holds the six causes then other exception
    task automatic enter(input logic [6:0] c, input logic [31:0] pc);
        @(posedge ref_clk);
        entry <= {1'b1, c, pc};
        @(posedge ref_clk);
        entry <= '0;
    endtask
    task automatic leave;
        @(posedge ref_clk);
        ret <= 1'b1;
        @(posedge ref_clk);
        ret <= 1'b0;
    endtask
    task automatic flt(input logic [3:0] f);
        @(posedge ref_clk);
        fault <= f;
        @(posedge ref_clk);
        fault <= '0;
    endtask
endmodule

// ---- bench/dsf_debug_status_tb.sv ----
// Purpose: self-checking bench for the debug status block
// Assumes: pipeline model drives entry, return and fault
// Notes: outputs sampled on the falling edge
`timescale 1ns/100ps
module dsf_debug_status_tb;
    logic ref_clk, reset, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, return_i;
    logic handler_active_q, step_allowed_q, test_port_reset_q, irq_q;
    logic [3:0] wb_adr_i, wb_sel_i;
    logic [31:0] wb_dat_i, wb_dat_o, debug_return_pc_q, q;
    dsf_pkg::dsf_entry_t entry_i;
    dsf_pkg::dsf_fault_t fault_i;
    int fails = 0;
    int checks = 0;
    int cyc_n = 0;
    localparam logic [31:0] ACT = 32'h4000_0000;
    dsf_debug_status dut (.ref_clk, .reset, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
        .wb_dat_i, .wb_sel_i, .wb_ack_o, .wb_dat_o, .entry_i, .return_i, .fault_i,
        .handler_active_q, .step_allowed_q, .test_port_reset_q, .debug_return_pc_q, .irq_q);
    dsf_pipe pipe (.ref_clk, .entry(entry_i), .ret(return_i), .fault(fault_i));
    initial begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end
    task automatic complete_run;
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    // a hung handshake ends here, counted as a mismatch
    always @(posedge ref_clk) begin
        cyc_n <= cyc_n + 1;
        if (cyc_n == 4000) begin
            fails++;
            complete_run;
        end
    end
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        {wb_cyc_i, wb_stb_i, wb_we_i} <= {2'b11, w};
        wb_adr_i <= a;
        wb_dat_i <= d;
        wb_sel_i <= 4'hf;
        @(posedge ref_clk);
        while (wb_ack_o !== 1'b1) @(posedge ref_clk);
        q = wb_dat_o;
        {wb_cyc_i, wb_stb_i} <= 2'b00;
    endtask
    task automatic rd(input string n, input logic [3:0] a, input logic [31:0] e);
        wb(1'b0, a, 32'h0);
        chk(n, e, q);
    endtask
    task automatic t_ctl;
        rd("cs", 4'h0, 32'h0);
        rd("pc", 4'hc, 32'h0);
        rd("unmapped", 4'h2, 32'h0);
        wb(1'b1, 4'h0, 32'hffff_ffff);
        rd("cs rw", 4'h0, 32'h0000_0180);
        @(negedge ref_clk);
        chk("port rst", 32'h1, {31'h0, test_port_reset_q});
        chk("step on", 32'h1, {31'h0, step_allowed_q});
        $display("test ctl done");
    endtask
    task automatic t_causes;
        logic [31:0] e;
        for (int k = 0; k < 6; k++) begin
            e = ACT | 32'h180 | (32'h1 << k) | ((k == 5) ? 32'h1000 : 32'h0);
            pipe.enter((7'h40 >> k) | 7'(k == 5), 32'h400 + k);
            rd("cause", 4'h0, e);
            rd("ret pc", 4'hc, 32'h400 + k);
            @(negedge ref_clk);
            chk("pc out", 32'h400 + k, debug_return_pc_q);
            chk("act on", 32'h1, {31'h0, handler_active_q});
            chk("step off", 32'h0, {31'h0, step_allowed_q});
            pipe.leave();
            rd("act clr", 4'h0, e & ~ACT);
            @(negedge ref_clk);
            chk("act off", 32'h0, {31'h0, handler_active_q});
        end
        wb(1'b1, 4'hc, 32'hbfc0_0380);
        rd("vec pc", 4'hc, 32'hbfc0_0380);
        wb(1'b1, 4'h0, 32'h0);
        @(negedge ref_clk);
        chk("port rst", 32'h0, {31'h0, test_port_reset_q});
        $display("test causes done");
    endtask
    task automatic t_irq;
        wb(1'b1, 4'h4, 32'h7);
        wb(1'b1, 4'h8, 32'h0);
        pipe.enter(7'h20, 32'h10);
        rd("irq stat", 4'h4, 32'h1);
        @(negedge ref_clk);
        chk("irq masked", 32'h0, {31'h0, irq_q});
        wb(1'b1, 4'h8, 32'h1);
        @(negedge ref_clk);
        chk("irq on", 32'h1, {31'h0, irq_q});
        wb(1'b1, 4'h4, 32'h1);
        @(negedge ref_clk);
        chk("irq off", 32'h0, {31'h0, irq_q});
        $display("test irq done");
    endtask
    // handler still active from the irq test
    task automatic t_faults;
        pipe.flt(4'b1000);
        rd("tlb bare", 4'h0, ACT | 32'h2);
        pipe.flt(4'b1010);
        pipe.flt(4'b0101);
        rd("flags", 4'h0, ACT | 32'hc02);
        wb(1'b1, 4'h0, 32'h0000_0c00);
        rd("w1 kept", 4'h0, ACT | 32'hc02);
        fork
            wb(1'b1, 4'h0, 32'h0);
            begin
                @(posedge ref_clk);
                pipe.flt(4'b1010);
            end
        join
        rd("set wins", 4'h0, ACT | 32'h802);
        wb(1'b1, 4'h0, 32'h0);
        rd("cleared", 4'h0, ACT | 32'h2);
        pipe.leave();
        pipe.flt(4'b1111);
        rd("idle flt", 4'h0, 32'h2);
        $display("test faults done");
    endtask
    initial begin
        reset = 1'b1;
        {wb_cyc_i, wb_stb_i, wb_we_i} = 3'h0;
        wb_adr_i = 4'h0;
        wb_sel_i = 4'h0;
        wb_dat_i = 32'h0;
        repeat (10) @(posedge ref_clk);
        reset <= 1'b0;
        t_ctl();
        t_causes();
        t_irq();
        t_faults();
        complete_run();
    end
endmodule
